// [design/motor_prot.sv]
// current based protection elements behind a classic wishbone slave
// assumes phase magnitudes and motor state come from same-clock logic
//
// Functional notes
// RQ1 - overload alarm only running above level
// RQ2 - overload alarm suppressed while starting
// RQ3 - overload level 1.01-1.50, delay 0.1 s steps
// RQ4 - modes off/latched/unlatched; variable frequency forbids unlatched (code holds only short circuit and backup as latched)
// RQ5 - short circuit trips above pickup for delay
// RQ6 - short circuit delay added after 45 ms
// RQ7 - short circuit pickup and delays settable ranges
// RQ8 - backup trip if current persists past delay
// RQ9 - main and backup timers start at pickup
// RQ10 - short circuit delay counts 10 ms steps
// RQ11 - jam acts after start above pickup
// RQ12 - jam levels and 0.5 s delays
// RQ13 - undercurrent acts below pickup for delay
// RQ14 - undercurrent only starting or running
// RQ15 - block from start delays undercurrent
// RQ16 - undercurrent block, levels, delays settable
// RQ17 - relay routing per alarm, trip, backup
// RQ18 - latched holds until reset, unlatched follows
// RQ19 - dropout clears element timer
`timescale 1ns/100ps
module motor_prot
  import motor_prot_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES,
  parameter int SC_INST_CNT = SC_INST_CYCLES
) (
  input wire logic core_clk, // 50 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire phase_s phase_i, // phase current magnitudes
  input wire motor_state_e motor_state_i, // stopped, starting, running
  output logic alarm_relay, // alarm relay drive
  output logic trip_relay, // trip relay drive
  output logic auxiliary_relay_one, // first auxiliary relay
  output logic auxiliary_relay_two, // second auxiliary relay
  output logic irq // level interrupt
);

  logic [31:0] cfg_reg [NUM_ELEM];
  logic [31:0] dly_reg [NUM_ELEM];
  logic [1:0] ctrl_reg;
  logic [15:0] fla_reg;
  logic [15:0] ct_reg;
  logic [13:0] uc_block_reg;
  logic [NUM_ELEM-1:0] status_reg;
  logic [NUM_ELEM-1:0] mask_reg;
  logic [NUM_ELEM-1:0] act_reg;
  logic [NUM_ELEM-1:0] act_next;
  logic [NUM_ELEM-1:0] pick;
  logic [NUM_ELEM-1:0] done;
  logic [23:0] cnt_reg [NUM_ELEM];
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [21:0] inst_cnt_reg;
  logic inst_done;
  logic sc_seen_reg;
  logic [6:0] sec_div_reg;
  logic [13:0] sec_cnt_reg;
  motor_state_e state_prev_reg;
  logic start_det;
  logic uc_blocked;
  logic latch_clr;
  logic wr_req;
  logic rd_hit;
  logic [7:0] eoff;
  logic [2:0] eidx;
  logic elem_sel;
  logic [31:0] rd_data;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // true when i / base exceeds lvl / div, done without a divider
  function automatic logic above(input logic [15:0] i,
                                 input logic [15:0] base,
                                 input logic [9:0] lvl,
                                 input logic [6:0] div);
    return ({16'h0, i} * {25'h0, div}) > ({22'h0, lvl} * {16'h0, base});
  endfunction

  function automatic logic below(input logic [15:0] i,
                                 input logic [15:0] base,
                                 input logic [9:0] lvl,
                                 input logic [6:0] div);
    return ({16'h0, i} * {25'h0, div}) < ({22'h0, lvl} * {16'h0, base});
  endfunction

  function automatic logic any_above(input phase_s p,
                                     input logic [15:0] base,
                                     input logic [9:0] lvl,
                                     input logic [6:0] div);
    return above(p.a, base, lvl, div) | above(p.b, base, lvl, div) |
           above(p.c, base, lvl, div);
  endfunction

  function automatic logic any_below(input phase_s p,
                                     input logic [15:0] base,
                                     input logic [9:0] lvl,
                                     input logic [6:0] div);
    return below(p.a, base, lvl, div) | below(p.b, base, lvl, div) |
           below(p.c, base, lvl, div);
  endfunction

  function automatic logic [9:0] lvl_of(input logic [31:0] c);
    elem_cfg_s s;
    s = elem_cfg_s'(c);
    return s.level;
  endfunction

  function automatic mode_e mode_of(input logic [31:0] c);
    elem_cfg_s s;
    s = elem_cfg_s'(c);
    return s.mode;
  endfunction

  function automatic logic rly_on(input logic [31:0] c, input int b);
    elem_cfg_s s;
    s = elem_cfg_s'(c);
    return s.relays[b];
  endfunction

  // bus decode
  assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign eoff = wb_adr_i - ADR_ELEM_BASE;
  assign eidx = eoff[5:3];
  assign elem_sel = (wb_adr_i >= ADR_ELEM_BASE) && (eoff[7:6] == 2'b00) &&
                    (32'(eidx) < NUM_ELEM);
  assign latch_clr = wr_req && (wb_adr_i == ADR_CTRL) && wb_sel_i[0] &&
                     wb_dat_i[CTRL_LATCH_CLR];
  assign rd_hit = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (elem_sel) begin
      rd_data = eoff[2] ? dly_reg[eidx] : cfg_reg[eidx];
    end else begin
      unique case (wb_adr_i)
        ADR_CTRL: rd_data = {30'h0, ctrl_reg[CTRL_VFD], 1'b0};
        ADR_FLA: rd_data = {16'h0, fla_reg};
        ADR_CT: rd_data = {16'h0, ct_reg};
        ADR_UC_BLOCK: rd_data = {18'h0, uc_block_reg};
        ADR_STATUS: rd_data = {25'h0, status_reg};
        ADR_MASK: rd_data = {25'h0, mask_reg};
        ADR_STATE: rd_data = {13'h0000, 3'(motor_state_i), 4'h0,
                              auxiliary_relay_two, auxiliary_relay_one,
                              trip_relay, alarm_relay, 1'b0, act_reg};
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // unmapped reads answer zero, unmapped writes are dropped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_hit) begin
      wb_dat_o <= rd_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= 2'b00;
      fla_reg <= FLA_RST;
      ct_reg <= CT_RST;
      uc_block_reg <= 14'h0000;
      mask_reg <= '0;
      for (int k = 0; k < NUM_ELEM; k++) begin
        cfg_reg[k] <= CFG_RST[k];
        dly_reg[k] <= DLY_RST[k];
      end
    end else if (wr_req) begin
      if (elem_sel && eoff[2]) begin
        dly_reg[eidx] <= wmerge(dly_reg[eidx], wb_dat_i, wb_sel_i);
      end else if (elem_sel) begin
        cfg_reg[eidx] <= wmerge(cfg_reg[eidx], wb_dat_i, wb_sel_i);
      end
      unique case (wb_adr_i)
        ADR_CTRL: ctrl_reg <= 2'(wmerge({30'h0, ctrl_reg}, wb_dat_i,
                                        wb_sel_i) & 32'h0000_0002);
        ADR_FLA: fla_reg <= 16'(wmerge({16'h0, fla_reg}, wb_dat_i,
                                       wb_sel_i));
        ADR_CT: ct_reg <= 16'(wmerge({16'h0, ct_reg}, wb_dat_i, wb_sel_i));
        ADR_UC_BLOCK: uc_block_reg <= 14'(wmerge({18'h0, uc_block_reg},
                                                 wb_dat_i, wb_sel_i));
        ADR_MASK: mask_reg <= 7'(wmerge({25'h0, mask_reg}, wb_dat_i,
                                        wb_sel_i));
        default: ;
      endcase
    end
  end

  // RQ10 10 ms time base
  always_ff @(posedge core_clk) begin
    if (rst || tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CNT - 1));

  // RQ15 start detection opens the block window
  assign start_det = (state_prev_reg == MOTOR_STOPPED) &&
                     (motor_state_i == MOTOR_STARTING);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_prev_reg <= MOTOR_STOPPED;
      sec_div_reg <= 7'h00;
      sec_cnt_reg <= 14'h0000;
    end else begin
      state_prev_reg <= motor_state_i;
      if (start_det) begin
        sec_div_reg <= 7'h00;
        sec_cnt_reg <= 14'h0000;
      end else if (tick && uc_blocked) begin
        if (sec_div_reg == 7'(TICKS_PER_SEC - 1)) begin
          sec_div_reg <= 7'h00;
          sec_cnt_reg <= sec_cnt_reg + 14'h0001;
        end else begin
          sec_div_reg <= sec_div_reg + 7'h01;
        end
      end
    end
  end
  // zero setting never blocks
  assign uc_blocked = sec_cnt_reg < uc_block_reg;

  // RQ6 fixed instantaneous operate time runs from pickup
  always_ff @(posedge core_clk) begin
    if (rst || !pick[E_SC]) begin
      inst_cnt_reg <= 22'h00_0000;
    end else if (!inst_done) begin
      inst_cnt_reg <= inst_cnt_reg + 22'h00_0001;
    end
  end
  assign inst_done = (inst_cnt_reg >= 22'(SC_INST_CNT));

  // pickup conditions
  always_comb begin
    // RQ1 overload alarm needs running; RQ2 starting suppresses it
    pick[E_OL] = (motor_state_i == MOTOR_RUNNING) &&
                 any_above(phase_i, fla_reg, lvl_of(cfg_reg[E_OL]),
                           FLA_LVL_DIV);
    // RQ5 any phase over the transformer multiple
    pick[E_SC] = any_above(phase_i, ct_reg, lvl_of(cfg_reg[E_SC]),
                           CT_LVL_DIV);
    // RQ9 backup timer shares the short circuit pickup
    pick[E_SCB] = pick[E_SC];
    // RQ11 jam only once start is complete
    for (int k = E_JAMA; k <= E_JAMT; k++) begin
      pick[k] = (motor_state_i == MOTOR_RUNNING) &&
                any_above(phase_i, fla_reg, lvl_of(cfg_reg[k]),
                          FLA_LVL_DIV);
    end
    // RQ13 undercurrent; RQ14 not while stopped; RQ15 block window
    for (int k = E_UCA; k <= E_UCT; k++) begin
      pick[k] = (motor_state_i != MOTOR_STOPPED) && !uc_blocked &&
                any_below(phase_i, fla_reg, lvl_of(cfg_reg[k]),
                          FLA_LVL_DIV);
    end
  end

  // RQ19 element timers clear on dropout and restart from zero
  // RQ6 short circuit delay waits out the operate time first
  always_ff @(posedge core_clk) begin
    for (int k = 0; k < NUM_ELEM; k++) begin
      if (rst || !pick[k] || mode_of(cfg_reg[k]) == MODE_OFF) begin
        cnt_reg[k] <= 24'h00_0000;
      end else if (tick && !done[k] && (k != E_SC || inst_done)) begin
        cnt_reg[k] <= cnt_reg[k] + 24'h00_0001;
      end
    end
  end

  // RQ3 RQ7 RQ12 RQ16 delay settings scaled to 10 ms ticks
  always_comb begin
    for (int k = 0; k < NUM_ELEM; k++) begin
      done[k] = pick[k] && (mode_of(cfg_reg[k]) != MODE_OFF) &&
                (cnt_reg[k] >= 24'(dly_reg[k][15:0]) * 24'(DLY_SCALE[k]));
    end
    // RQ6 programmed delay counts on top of 45 ms
    done[E_SC] = done[E_SC] && inst_done;
    // RQ8 backup only after the main trip has operated
    done[E_SCB] = done[E_SCB] && inst_done && sc_seen_reg;
  end

  always_ff @(posedge core_clk) begin
    if (rst || !pick[E_SC]) begin
      sc_seen_reg <= 1'b0;
    end else if (done[E_SC]) begin
      sc_seen_reg <= 1'b1;
    end
  end

  // RQ18 latched holds until clear, a live condition sets again
  always_comb begin
    for (int k = 0; k < NUM_ELEM; k++) begin
      unique case (mode_of(cfg_reg[k]))
        MODE_LATCHED: act_next[k] = done[k] | (act_reg[k] & ~latch_clr);
        // RQ4 variable frequency treats unlatched short circuit as latched
        MODE_UNLATCHED: act_next[k] = (ctrl_reg[CTRL_VFD] &&
                                       ELEM_KIND[k] != 2'h0 &&
                                       (k == E_SC || k == E_SCB)) ?
                                      (done[k] | (act_reg[k] & ~latch_clr)) :
                                      done[k];
        default: act_next[k] = 1'b0;
      endcase
    end
  end

  // rising outputs set sticky status; a new event beats the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      act_reg <= '0;
      status_reg <= '0;
    end else begin
      act_reg <= act_next;
      status_reg <= (status_reg &
                     ~((wr_req && wb_adr_i == ADR_STATUS && wb_sel_i[0]) ?
                       wb_dat_i[NUM_ELEM-1:0] : 7'h00)) |
                    (act_next & ~act_reg);
    end
  end

  // RQ17 relay routing; backup never reaches the trip relay
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarm_relay <= 1'b0;
      trip_relay <= 1'b0;
      auxiliary_relay_one <= 1'b0;
      auxiliary_relay_two <= 1'b0;
      irq <= 1'b0;
    end else begin
      alarm_relay <= 1'b0;
      trip_relay <= 1'b0;
      auxiliary_relay_one <= 1'b0;
      auxiliary_relay_two <= 1'b0;
      for (int k = 0; k < NUM_ELEM; k++) begin
        if (act_reg[k] && rly_on(cfg_reg[k], RLY_MAIN)) begin
          if (ELEM_KIND[k] == 2'h0) begin
            alarm_relay <= 1'b1;
          end else if (ELEM_KIND[k] == 2'h1) begin
            trip_relay <= 1'b1;
          end
        end
        if (act_reg[k] && rly_on(cfg_reg[k], RLY_AUXILIARY_RELAY_ONE)) begin
          auxiliary_relay_one <= 1'b1;
        end
        if (act_reg[k] && rly_on(cfg_reg[k], RLY_AUXILIARY_RELAY_TWO)) begin
          auxiliary_relay_two <= 1'b1;
        end
      end
      irq <= |(status_reg & mask_reg);
    end
  end

endmodule

// [inc/motor_prot_pkg.sv]
// constants, register map and carrier types for the current protection block
// assumes a 50 MHz core clock and phase magnitudes in the same units as the
// full load current and transformer primary settings
package motor_prot_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
  localparam int SC_INST_MS = 45;
  localparam int SC_INST_CYCLES = SC_INST_MS * (CLK_HZ / 1000);
  localparam int TICKS_PER_SEC = 1000 / TICK_MS;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_FLA = 8'h04;
  localparam logic [7:0] ADR_CT = 8'h08;
  localparam logic [7:0] ADR_UC_BLOCK = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_MASK = 8'h14;
  localparam logic [7:0] ADR_STATE = 8'h18;
  localparam logic [7:0] ADR_ELEM_BASE = 8'h20;

  localparam int CTRL_LATCH_CLR = 0;
  localparam int CTRL_VFD = 1;

  localparam int NUM_ELEM = 7;
  localparam int E_OL = 0;
  localparam int E_SC = 1;
  localparam int E_SCB = 2;
  localparam int E_JAMA = 3;
  localparam int E_JAMT = 4;
  localparam int E_UCA = 5;
  localparam int E_UCT = 6;

  // relay mask bits: primary (alarm or trip relay, none for a backup element), aux one, aux two
  localparam int RLY_MAIN = 0;
  localparam int RLY_AUXILIARY_RELAY_ONE = 1;
  localparam int RLY_AUXILIARY_RELAY_TWO = 2;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_LATCHED = 2'b01,
    MODE_UNLATCHED = 2'b10
  } mode_e;

  typedef enum logic [2:0] {
    MOTOR_STOPPED = 3'b001,
    MOTOR_STARTING = 3'b010,
    MOTOR_RUNNING = 3'b100
  } motor_state_e;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } phase_s;

  typedef struct packed {
    logic [5:0] rsvd_hi;
    logic [9:0] level;
    logic [10:0] rsvd_lo;
    logic [2:0] relays;
    mode_e mode;
  } elem_cfg_s;

  // delay unit of each element in 10 ms ticks
  localparam logic [6:0] DLY_SCALE [NUM_ELEM] =
    '{7'h0A, 7'h01, 7'h01, 7'h32, 7'h32, 7'h64, 7'h64};
  // 0 alarm, 1 trip, 2 backup trip
  localparam logic [1:0] ELEM_KIND [NUM_ELEM] =
    '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1};
  localparam logic [31:0] CFG_RST [NUM_ELEM] =
    '{32'h0065_0004, 32'h0064_0004, 32'h0000_0008, 32'h0096_0004,
      32'h0096_0004, 32'h0046_0004, 32'h0046_0004};
  localparam logic [31:0] DLY_RST [NUM_ELEM] =
    '{32'h0000_000A, 32'h0000_0000, 32'h0000_0014, 32'h0000_0002,
      32'h0000_0002, 32'h0000_0001, 32'h0000_0001};
  localparam logic [15:0] FLA_RST = 16'h0064;
  localparam logic [15:0] CT_RST = 16'h0064;
  // level units: hundredths of full load, tenths of transformer primary
  localparam logic [6:0] FLA_LVL_DIV = 7'h64;
  localparam logic [6:0] CT_LVL_DIV = 7'h0A;
endpackage

// [verif/motor_prot_assertions.sv]
// port checker for the current protection block
// bound to motor_prot; watches its ports only, one clock domain
`timescale 1ns/100ps
module motor_prot_checker
  import motor_prot_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire phase_s phase_i, // phases
  input wire motor_state_e motor_state_i, // motor state
  input wire logic alarm_relay, // alarm
  input wire logic trip_relay, // trip
  input wire logic auxiliary_relay_one, // aux one
  input wire logic auxiliary_relay_two, // aux two
  input wire logic irq // interrupt
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rdq = take && !wb_we_i;
  wire [3:0] rly = {auxiliary_relay_two, auxiliary_relay_one, trip_relay,
    alarm_relay};
  // nothing may pick up on a stopped, unloaded motor left alone by software
  wire quiet = motor_state_i == MOTOR_STOPPED && phase_i == '0 && !wb_cyc_i;

  ack_one_cycle_a: assert property (take |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_needs_cycle_a: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack without a request");
  unmapped_reads_zero_a: assert property (
    rdq && wb_adr_i >= 8'h58 |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  clear_bit_zero_a: assert property (
    rdq && wb_adr_i == ADR_CTRL |=> !wb_dat_o[CTRL_LATCH_CLR])
    else $error("latch clear bit reads one");
  read_data_holds_a: assert property (!rdq |=> $stable(wb_dat_o))
    else $error("read data moved without a read");
  reset_outputs_low_a: assert property (
    $fell(rst) |-> rly == 4'h0 && !irq && !wb_ack_o)
    else $error("outputs active after reset");
  irq_fall_write_a: assert property (
    $fell(irq) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("interrupt dropped without a write");
  stopped_quiet_a: assert property (
    quiet [*4] |=> (rly & ~$past(rly)) == 4'h0)
    else $error("relay picked up on a stopped motor");
endmodule

bind motor_prot motor_prot_checker u_chk (
  .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_i(phase_i),
  .motor_state_i(motor_state_i), .alarm_relay(alarm_relay),
  .trip_relay(trip_relay), .auxiliary_relay_one(auxiliary_relay_one),
  .auxiliary_relay_two(auxiliary_relay_two), .irq(irq));

// [verif/line_side.sv]
// line side model: current measurement front end and relay contacts
// assumes the bench sets wanted magnitudes and state at clock edges
`timescale 1ns/100ps
module line_side
  import motor_prot_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic [15:0] amps_a, // wanted phase a
  input wire logic [15:0] amps_bc, // wanted phases b and c
  input wire motor_state_e state_set, // wanted motor state
  input wire logic [3:0] coil, // auxiliary_relay_two, auxiliary_relay_one, trip, alarm drives
  output phase_s phase_o, // measured magnitudes
  output motor_state_e state_o, // reported state
  output logic [3:0] contact // closed contacts
);
  // one sample of lag, as a real measurement path would add
  always_ff @(posedge core_clk) begin
    phase_o <= '{a: amps_a, b: amps_bc, c: amps_bc};
    state_o <= state_set;
  end
  assign contact = coil;
endmodule

// [verif/motor_prot_bench.sv]
// self-checking bench for the current protection block
// one 50 MHz clock; ticks shortened to 10 cycles, 45 ms to 45 cycles
`timescale 1ns/100ps
module motor_prot_bench;
  import motor_prot_pkg::*;
  localparam logic [3:0] AL = 4'h1;
  localparam logic [3:0] TR = 4'h2;
  localparam logic [3:0] X1 = 4'h4;
  localparam logic [3:0] X2 = 4'h8;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic irq;
  logic [15:0] amp_a = 16'h0000;
  logic [15:0] amp_bc = 16'h0000;
  motor_state_e st = MOTOR_STOPPED;
  phase_s ph;
  motor_state_e ms;
  wire [3:0] coil;
  wire [3:0] rly;
  int err_total = 0;
  int compares = 0;

  always #10 core_clk = ~core_clk;

  motor_prot #(.TICK_CNT(10), .SC_INST_CNT(45)) u_dut (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .phase_i(ph), .motor_state_i(ms),
    .alarm_relay(coil[0]), .trip_relay(coil[1]),
    .auxiliary_relay_one(coil[2]), .auxiliary_relay_two(coil[3]),
    .irq(irq));
  line_side u_line (.core_clk(core_clk), .amps_a(amp_a), .amps_bc(amp_bc),
    .state_set(st), .coil(coil), .phase_o(ph), .state_o(ms), .contact(rly));

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; values read right after an edge are those sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk({31'h0, ack}, 32'h1);
        tally_and_finish();
      end
      @(posedge core_clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  task automatic wait_rly(input logic [3:0] m, input logic [3:0] v,
                          input int n);
    int i;
    i = 0;
    while ((rly & m) !== v) begin
      i++;
      if (i > n) begin
        chk({28'h0, rly & m}, {28'h0, v});
        tally_and_finish();
      end
      @(posedge core_clk);
    end
    chk({28'h0, rly & m}, {28'h0, v});
  endtask

  // remembers the first wrong value so one compare covers the whole span
  task automatic hold_rly(input logic [3:0] m, input logic [3:0] v,
                          input int n);
    logic [3:0] seen;
    seen = v;
    repeat (n) begin
      @(posedge core_clk);
      if ((rly & m) !== v && seen === v)
        seen = rly & m;
    end
    chk({28'h0, seen}, {28'h0, v});
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(ADR_FLA, 32'h0000_0064);
    rd(ADR_CT, 32'h0000_0064);
    rd(ADR_ELEM_BASE, 32'h0065_0004);
    rd(8'h24, 32'h0000_000A);
    rd(8'h30, 32'h0000_0008);
    rd(8'h34, 32'h0000_0014);
    wr(8'h60, 32'hFFFF_FFFF);
    rd(8'h60, 32'h0000_0000);
    rd(ADR_CTRL, 32'h0000_0000);
    rd(ADR_STATE, 32'h0001_0000);
    $display("test defaults done");
    amp_bc <= 16'h0064;
    amp_a <= 16'h0066;
    st <= MOTOR_STARTING;
    wr(8'h24, 32'h0000_0002);
    wr(ADR_ELEM_BASE, 32'h0065_0006);
    wr(ADR_MASK, 32'h0000_0001);
    hold_rly(AL, 4'h0, 300);
    st <= MOTOR_RUNNING;
    hold_rly(AL, 4'h0, 180);
    wait_rly(AL, AL, 40);
    chk({31'h0, irq}, 32'h1);
    amp_a <= 16'h0065;
    wait_rly(AL, 4'h0, 10);
    rd(ADR_STATUS, 32'h0000_0001);
    wr(ADR_MASK, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    wr(ADR_MASK, 32'h0000_0001);
    chk({31'h0, irq}, 32'h1);
    wr(ADR_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0);
    rd(ADR_STATUS, 32'h0000_0000);
    wr(ADR_ELEM_BASE, 32'h0000_0000);
    $display("test overload done");
    amp_a <= 16'h0064;
    wr(ADR_CTRL, 32'h0000_0002);
    wr(8'h28, 32'h0014_0006);
    wr(8'h2C, 32'h0000_0003);
    wr(8'h30, 32'h0000_000D);
    wr(8'h34, 32'h0000_000F);
    amp_a <= 16'h00FA;
    hold_rly(4'hF, 4'h0, 62);
    wait_rly(4'hF, TR, 30);
    hold_rly(X1, 4'h0, 50);
    wait_rly(4'hF, TR | X1, 40);
    amp_a <= 16'h0064;
    hold_rly(4'hF, TR | X1, 30);
    wr(ADR_CTRL, 32'h0000_0003);
    wait_rly(4'hF, 4'h0, 5);
    wr(ADR_CTRL, 32'h0000_0000);
    $display("test short circuit done");
    wr(8'h40, 32'h0096_0012);
    wr(8'h44, 32'h0000_0001);
    amp_a <= 16'h00A0;
    hold_rly(X2, 4'h0, 300);
    amp_a <= 16'h0064;
    repeat (20) @(posedge core_clk);
    amp_a <= 16'h00A0;
    hold_rly(X2, 4'h0, 470);
    wait_rly(4'hF, X2, 60);
    amp_a <= 16'h0064;
    wait_rly(X2, 4'h0, 10);
    $display("test jam done");
    st <= MOTOR_STOPPED;
    amp_a <= 16'h0000;
    amp_bc <= 16'h0000;
    wr(8'h54, 32'h0000_0001);
    wr(8'h50, 32'h0046_0005);
    hold_rly(TR, 4'h0, 1200);
    wr(ADR_UC_BLOCK, 32'h0000_0001);
    amp_a <= 16'h0032;
    amp_bc <= 16'h0064;
    st <= MOTOR_STARTING;
    hold_rly(TR, 4'h0, 1850);
    wait_rly(4'hF, TR, 250);
    amp_a <= 16'h0064;
    hold_rly(TR, TR, 20);
    wr(ADR_CTRL, 32'h0000_0001);
    wait_rly(TR, 4'h0, 5);
    wr(ADR_UC_BLOCK, 32'h0000_0000);
    st <= MOTOR_STOPPED;
    amp_a <= 16'h0032;
    repeat (4) @(posedge core_clk);
    st <= MOTOR_STARTING;
    hold_rly(TR, 4'h0, 900);
    wait_rly(TR, TR, 200);
    $display("test undercurrent done");
    tally_and_finish();
  end
endmodule
